// *** wdog_pkg.sv ***
package wdog_pkg;
  localparam int CNT_W = 11;
  localparam logic [CNT_W-1:0] POWER_ON_TICKS = 11'h00A;
  localparam logic [CNT_W-1:0] SYNC_TICKS = 11'h1C2;
  localparam logic [CNT_W-1:0] SHORT_CLOSED_TICKS = 11'h00F;
  localparam logic [CNT_W-1:0] SHORT_OPEN_TICKS = 11'h00A;
  localparam logic [CNT_W-1:0] LONG_CLOSED_TICKS = 11'h5DC;
  localparam logic [CNT_W-1:0] LONG_OPEN_TICKS = 11'h3E8;
  localparam logic [CNT_W-1:0] PULSE_TICKS = 11'h004;
  localparam int PERIOD_W = 16;
  localparam logic [PERIOD_W-1:0] PERIOD_CYCLES_DEF = 16'h0064;
  typedef enum logic [2:0] {ST_POWER_ON, ST_SYNC, ST_CLOSED, ST_OPEN, ST_PULSE,
    ST_IDLE} wd_state_t;
endpackage

// *** tick_if.sv ***
`timescale 1ns/1ps
interface tick_if;
  logic tick;
  modport gen (output tick);
  modport use_tick (input tick);
endinterface

// *** period_tick.sv ***
`timescale 1ns/1ps
module period_tick
  import wdog_pkg::*;
#(
  parameter int PERIOD_W = 16
)(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [PERIOD_W-1:0] period_cycles,
  tick_if.gen tk
);
  logic [PERIOD_W-1:0] div_q;
  logic tick_q;
  assign tk.tick = tick_q;
  // one-cycle tick every period_cycles clocks
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      div_q <= '0;
      tick_q <= 1'b0;
    end
    else if (clk_en)
    begin
      if (div_q + PERIOD_W'(1) >= period_cycles)
      begin
        div_q <= '0;
        tick_q <= 1'b1;
      end
      else
      begin
        div_q <= div_q + PERIOD_W'(1);
        tick_q <= 1'b0;
      end
    end
  end
endmodule // period_tick

// *** windowed_watchdog_core.sv ***
`timescale 1ns/1ps
module windowed_watchdog_core
  import wdog_pkg::*;
#(
  parameter int PERIOD_W = wdog_pkg::PERIOD_W
)(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [PERIOD_W-1:0] period_cycles,
  input wire logic power_good,
  input wire logic trigger_in,
  input wire logic mode_long,
  input wire logic check_disable_n,
  output logic reset_out_n,
  output logic trigger_accepted,
  output logic fault_seen
);
  import wdog_pkg::*;

  ////////////////////////////////////////////////////////////////////
  tick_if tk();
  period_tick #(.PERIOD_W(PERIOD_W)) u_tick
  (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .period_cycles(period_cycles),
    .tk(tk)
  );

  ////////////////////////////////////////////////////////////////////
  logic [1:0] trig_s_q, mode_s_q, dis_s_q, pg_s_q;
  logic trig_last_q;
  logic trig_rise;
  // two-stage synchronisers for pin inputs
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      trig_s_q <= 2'h0;
      mode_s_q <= 2'h0;
      dis_s_q <= 2'h3;
      pg_s_q <= 2'h0;
    end
    else if (clk_en)
    begin
      trig_s_q <= {trig_s_q[0], trigger_in};
      mode_s_q <= {mode_s_q[0], mode_long};
      dis_s_q <= {dis_s_q[0], check_disable_n};
      pg_s_q <= {pg_s_q[0], power_good};
    end
  end

  // last synchronised trigger level, idle low like the pin
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      trig_last_q <= 1'b0;
    else if (clk_en)
      trig_last_q <= trig_s_q[1];
  end
  // rising edge of the synchronised trigger
  assign trig_rise = trig_s_q[1] & ~trig_last_q;

  ////////////////////////////////////////////////////////////////////
  wd_state_t state_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] closed_len, open_len;
  logic enabled;
  assign enabled = dis_s_q[1];
  // window lengths from mode
  assign closed_len = mode_s_q[1] ? LONG_CLOSED_TICKS : SHORT_CLOSED_TICKS;
  assign open_len = mode_s_q[1] ? LONG_OPEN_TICKS : SHORT_OPEN_TICKS;

  // supervision sequence; counts advance on ticks only
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      state_q <= ST_POWER_ON;
      cnt_q <= '0;
      reset_out_n <= 1'b0;
      trigger_accepted <= 1'b0;
      fault_seen <= 1'b0;
    end
    else if (clk_en)
    begin
      // event pulses default low, one cycle wide
      trigger_accepted <= 1'b0;
      fault_seen <= 1'b0;
      // undervoltage overrides every state
      if (!pg_s_q[1])
      begin
        state_q <= ST_POWER_ON;
        cnt_q <= '0;
        reset_out_n <= 1'b0;
      end
      else
      begin
        unique case (state_q)
          // hold reset low for the power-on delay
          ST_POWER_ON:
          begin
            reset_out_n <= 1'b0;
            if (tk.tick)
            begin
              if (cnt_q + CNT_W'(1) >= POWER_ON_TICKS)
              begin
                cnt_q <= '0;
                reset_out_n <= 1'b1;
                state_q <= enabled ? ST_SYNC : ST_IDLE;
              end
              else
                cnt_q <= cnt_q + CNT_W'(1);
            end
          end
          // checking disabled, reset released
          ST_IDLE:
          begin
            reset_out_n <= 1'b1;
            cnt_q <= '0;
            if (enabled)
              state_q <= ST_SYNC;
          end
          // wait for the first trigger after release
          ST_SYNC:
          begin
            if (!enabled)
              state_q <= ST_IDLE;
            else if (trig_rise)
            begin
              trigger_accepted <= 1'b1;
              cnt_q <= '0;
              state_q <= ST_CLOSED;
            end
            else if (tk.tick)
            begin
              if (cnt_q + CNT_W'(1) >= SYNC_TICKS)
              begin
                cnt_q <= '0;
                fault_seen <= 1'b1;
                reset_out_n <= 1'b0;
                state_q <= ST_PULSE;
              end
              else
                cnt_q <= cnt_q + CNT_W'(1);
            end
          end
          // any trigger here is a fault
          ST_CLOSED:
          begin
            if (!enabled)
              state_q <= ST_IDLE;
            else if (trig_rise)
            begin
              cnt_q <= '0;
              fault_seen <= 1'b1;
              reset_out_n <= 1'b0;
              state_q <= ST_PULSE;
            end
            else if (tk.tick)
            begin
              if (cnt_q + CNT_W'(1) >= closed_len)
              begin
                cnt_q <= '0;
                state_q <= ST_OPEN;
              end
              else
                cnt_q <= cnt_q + CNT_W'(1);
            end
          end
          // a trigger must land before the window ends
          ST_OPEN:
          begin
            if (!enabled)
              state_q <= ST_IDLE;
            else if (trig_rise)
            begin
              trigger_accepted <= 1'b1;
              cnt_q <= '0;
              state_q <= ST_CLOSED;
            end
            else if (tk.tick)
            begin
              if (cnt_q + CNT_W'(1) >= open_len)
              begin
                cnt_q <= '0;
                fault_seen <= 1'b1;
                reset_out_n <= 1'b0;
                state_q <= ST_PULSE;
              end
              else
                cnt_q <= cnt_q + CNT_W'(1);
            end
          end
          // watchdog reset pulse, restarted by a trigger
          ST_PULSE:
          begin
            reset_out_n <= 1'b0;
            if (trig_rise)
            begin
              trigger_accepted <= 1'b1;
              cnt_q <= '0;
            end
            else if (tk.tick)
            begin
              if (cnt_q + CNT_W'(1) >= PULSE_TICKS)
              begin
                cnt_q <= '0;
                reset_out_n <= 1'b1;
                state_q <= enabled ? ST_SYNC : ST_IDLE;
              end
              else
                cnt_q <= cnt_q + CNT_W'(1);
            end
          end
          default:
            state_q <= ST_POWER_ON;
        endcase
      end
    end
  end
endmodule // windowed_watchdog_core

// *** wd_chk.sv ***
`timescale 1ns/1ps
module wd_chk #(
  parameter int PERIOD_W = 16
)(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [PERIOD_W-1:0] period_cycles,
  input wire logic power_good,
  input wire logic trigger_in,
  input wire logic mode_long,
  input wire logic check_disable_n,
  input wire logic reset_out_n,
  input wire logic trigger_accepted,
  input wire logic fault_seen
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // one tick per core clock
  wire fast = period_cycles <= 16'h0001;
  ////////////////////////////////////////
  under_volt_a: assert property (!power_good [*4] |-> !reset_out_n)
    else $error("reset high in undervoltage");
  power_hold_a: assert property ($rose(power_good) && fast |->
    !reset_out_n [*8] ##1 !reset_out_n [*3])
    else $error("power-on delay short");
  power_end_a: assert property ($rose(power_good) && fast |-> ##[10:40] reset_out_n)
    else $error("power-on reset stuck");
  sync_wait_a: assert property ($rose(reset_out_n) && fast |->
    ##[1:470] (fault_seen || trigger_accepted || !check_disable_n))
    else $error("sync wait too long");
  pulse_width_a: assert property (fault_seen && fast |-> !reset_out_n [*4])
    else $error("reset pulse short");
  pulse_extend_a: assert property (trigger_accepted && !reset_out_n && fast |->
    !reset_out_n [*4])
    else $error("pulse not restarted");
  closed_short_a: assert property (trigger_accepted && reset_out_n |=>
    !trigger_accepted [*6])
    else $error("accept in closed window");
  disabled_calm_a: assert property (!check_disable_n [*4] |-> !fault_seen)
    else $error("fault while disabled");
  // main scenarios
  cover property (fault_seen);
  cover property (trigger_accepted && mode_long);
  cover property (trigger_accepted && !reset_out_n);
endmodule // wd_chk
bind windowed_watchdog_core wd_chk #(.PERIOD_W(PERIOD_W)) chk (.core_clk(core_clk),
  .sys_rst(sys_rst), .clk_en(clk_en), .period_cycles(period_cycles), .power_good(power_good),
  .trigger_in(trigger_in), .mode_long(mode_long), .check_disable_n(check_disable_n),
  .reset_out_n(reset_out_n), .trigger_accepted(trigger_accepted), .fault_seen(fault_seen));

// *** mcu_model.sv ***
`timescale 1ns/1ps
module mcu_model (
  input wire logic core_clk,
  input wire logic fire,
  output logic trigger_in
);
  logic [1:0] hold_q = 2'h0;
  // two-cycle trigger pulse per request
  always_ff @(posedge core_clk)
  begin
    hold_q <= fire ? 2'h2 : hold_q - 2'(hold_q != 2'h0);
  end
  assign trigger_in = hold_q != 2'h0;
endmodule // mcu_model

// *** windowed_watchdog_core_bench.sv ***
`timescale 1ns/1ps
module windowed_watchdog_core_bench;
  logic core_clk = 0, sys_rst = 1, power_good = 0, mode_long = 0, check_disable_n = 1;
  logic fire = 0, trigger_in, reset_out_n, trigger_accepted, fault_seen;
  logic [1:0] ev;
  logic [15:0] period_cycles = 16'h0001;
  int miscompares = 0, checked = 0, n, cyc = 0;
  windowed_watchdog_core uut (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(1'b1),
    .period_cycles(period_cycles), .power_good(power_good), .trigger_in(trigger_in),
    .mode_long(mode_long), .check_disable_n(check_disable_n), .reset_out_n(reset_out_n),
    .trigger_accepted(trigger_accepted), .fault_seen(fault_seen));
  mcu_model mcu (.core_clk(core_clk), .fire(fire), .trigger_in(trigger_in));
  // clock and hang guard
  initial forever #12.5 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      test_done();
    end
  end
  ////////////////////////////////////////
  task automatic test_done();
    if (miscompares == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic cmp_ev(input logic [1:0] g, input logic [1:0] e);
    checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("[ERR] %0t event %b not %b", $time, g, e);
    end
  endtask
  task automatic cmp_bit(input logic g, input logic e);
    checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("[ERR] %0t level %b not %b", $time, g, e);
    end
  endtask
  task automatic step(input int d);
    repeat (d)
    begin
      @(posedge core_clk);
      #1;
    end
  endtask
  task automatic pulse(input int d);
    step(d);
    fire = 1;
    step(1);
    fire = 0;
  endtask
  // first fault or accept, or none by the limit
  task automatic watch(input int lim);
    ev = 2'b00;
    n = 0;
    while (ev === 2'b00 && n < lim)
    begin
      step(1);
      n++;
      ev = {fault_seen, trigger_accepted};
    end
  endtask
  task automatic rel();
    n = 0;
    while (reset_out_n !== 1'b1 && n < 100)
    begin
      step(1);
      n++;
    end
  endtask
  ////////////////////////////////////////
  task automatic t_power();
    step(4);
    power_good = 1;
    step(8);
    cmp_bit(reset_out_n, 1'b0);
    rel();
    cmp_bit(reset_out_n, 1'b1);
  endtask
  task automatic t_sync();
    watch(500);
    cmp_ev(ev, 2'b10);
    cmp_bit(n >= 440 && n <= 470, 1'b1);
    cmp_bit(reset_out_n, 1'b0);
  endtask
  task automatic t_short();
    rel();
    pulse(2);
    watch(20);
    cmp_ev(ev, 2'b01);
    pulse(16);
    watch(30);
    cmp_ev(ev, 2'b01);
    watch(40);
    cmp_ev(ev, 2'b10);
    cmp_bit(n >= 20 && n <= 30, 1'b1);
  endtask
  task automatic t_closed();
    rel();
    pulse(2);
    watch(20);
    cmp_ev(ev, 2'b01);
    pulse(2);
    watch(10);
    cmp_ev(ev, 2'b10);
    // third trigger lands on the last cycle of the pulse
    pulse(0);
    watch(10);
    cmp_ev(ev, 2'b01);
    cmp_bit(reset_out_n, 1'b0);
    rel();
    cmp_bit(n == 4, 1'b1);
  endtask
  // slower tick stretches the sync wait and the pulse
  task automatic t_period();
    rel();
    period_cycles = 16'h0003;
    watch(1500);
    cmp_ev(ev, 2'b10);
    cmp_bit(n >= 1340 && n <= 1360, 1'b1);
    rel();
    cmp_bit(n >= 11 && n <= 13, 1'b1);
    period_cycles = 16'h0001;
  endtask
  task automatic t_long();
    mode_long = 1;
    rel();
    pulse(5);
    watch(20);
    pulse(1890);
    watch(200);
    cmp_ev(ev, 2'b01);
    pulse(600);
    watch(50);
    cmp_ev(ev, 2'b10);
  endtask
  task automatic t_dis();
    rel();
    check_disable_n = 0;
    step(5);
    watch(600);
    cmp_ev(ev, 2'b00);
    check_disable_n = 1;
    power_good = 0;
    step(5);
    cmp_bit(reset_out_n, 1'b0);
  endtask
  initial
  begin
    step(8);
    sys_rst = 0;
    t_power();
    t_sync();
    t_short();
    t_closed();
    t_long();
    t_period();
    t_dis();
    test_done();
  end
endmodule // windowed_watchdog_core_bench
